// ---- hw/timer_pkg.sv ----
/*
 * Shared constants and carrier types for the 16-bit standalone timer and the
 * pairable 16/32-bit timer block.
 * Assumes a 20 MHz single clock and a plain register port with 16-bit data.
 */
package timer_pkg;

    // register word indices on the plain register port
    localparam logic [3:0] ADDR_SA_CTL = 4'h0;
    localparam logic [3:0] ADDR_SA_CNT = 4'h1;
    localparam logic [3:0] ADDR_SA_PER = 4'h2;
    localparam logic [3:0] ADDR_EV_CTL = 4'h3;
    localparam logic [3:0] ADDR_EV_CNT = 4'h4;
    localparam logic [3:0] ADDR_EV_PER = 4'h5;
    localparam logic [3:0] ADDR_OD_CTL = 4'h6;
    localparam logic [3:0] ADDR_OD_CNT = 4'h7;
    localparam logic [3:0] ADDR_OD_PER = 4'h8;

    // control field positions
    localparam int BIT_RUN = 15;
    localparam int BIT_IDLE = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_T32 = 3;
    localparam int BIT_SYNC = 2;
    localparam int BIT_SRC = 1;

    // implemented control bits per channel
    localparam logic [15:0] MASK_SA = 16'hA076;
    localparam logic [15:0] MASK_EV = 16'hA07A;
    localparam logic [15:0] MASK_OD = 16'hA072;

    // reset values
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] PER_RESET = 16'hFFFF;

    // prescaler terminal counts
    localparam logic [7:0] PS_DIV1 = 8'h00;
    localparam logic [7:0] PS_DIV8 = 8'h07;
    localparam logic [7:0] PS_DIV64 = 8'h3F;
    localparam logic [7:0] PS_DIV256 = 8'hFF;

    // channel indices
    localparam int CH_SA = 0;
    localparam int CH_EV = 1;
    localparam int CH_OD = 2;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic [15:0] ctl;
        logic [15:0] cnt;
        logic [15:0] per;
        logic [7:0] pre;
    } chan_t;

    typedef struct packed {
        chan_t [2:0] ch;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] prev;
        logic [2:0] irq;
        logic adcTrig;
        logic [1:0] dma;
        logic [15:0] rdata;
    } state_t;

endpackage

// ---- hw/timer16_pair32.sv ----
/*
 * Standalone 16-bit timer plus one pairable timer pair (even and odd member)
 * that runs as two 16-bit timers or as one 32-bit timer.
 * Assumes idleMode and sleepMode come from logic on clk; external clock
 * pins are asynchronous and are synchronised here.
 */
// Added by the designer: the plain strobed port and the register offsets.
// How it works
// - standalone 16-bit timer, sync or async counter
// - irq on period match or gate fall
// - control bit 15 starts and stops counting
// - bit 13 set halts timer in idle
// - bit 6 gates counting, internal clock only
// - bits 5-4 divide by 1,8,64,256
// - bit 2 syncs external clock when selected
// - bit 1 picks external pin or instruction clock
// - unimplemented control bits read as zero
// - pair runs as two 16-bit timers, no async
// - chained pair is 32-bit timer or counter
// - even control bit 3 joins the pair
// - even holds low word, odd high word
// - 32-bit uses even controls, odd irq flag
// - 32-bit count match raises irq
// - this pair drives the converter trigger
// - only this pair requests dma, gives time base
// - even run bit controls whole pair when chained
// - timers may run in idle; in sleep only the standalone timer runs, async external clock only
`timescale 1ns/1ns
module timer16_pair32 (
    input wire logic clk,
    input wire logic rst_n,
    input wire timer_pkg::bus_req_t busReq,
    output logic [15:0] rdata,
    input wire logic [2:0] extClkPin,
    input wire logic idleMode,
    input wire logic sleepMode,
    output logic [2:0] irqPulse,
    output logic adcTrig,
    output logic [1:0] dmaReq,
    output logic [15:0] timeBaseEven,
    output logic [15:0] timeBaseOdd
);

    timer_pkg::state_t s_reg;
    timer_pkg::state_t s_next;

    function automatic logic [7:0] psLimit(input logic [1:0] sel);
        case (sel)
            2'h0: psLimit = timer_pkg::PS_DIV1;
            2'h1: psLimit = timer_pkg::PS_DIV8;
            2'h2: psLimit = timer_pkg::PS_DIV64;
            default: psLimit = timer_pkg::PS_DIV256;
        endcase
    endfunction

    function automatic logic [15:0] ctlMask(input int c);
        if (c == timer_pkg::CH_SA) begin
            ctlMask = timer_pkg::MASK_SA;
        end else if (c == timer_pkg::CH_EV) begin
            ctlMask = timer_pkg::MASK_EV;
        end else begin
            ctlMask = timer_pkg::MASK_OD;
        end
    endfunction

    always_comb begin
        logic pair32;
        logic [15:0] cfg;
        logic [2:0] tick;
        logic [2:0] gfall;
        int pin;
        logic asyncMode;
        logic en;
        logic gated;
        logic ev;
        logic [31:0] cnt32;
        pair32 = 1'b0;
        cfg = 16'h0000;
        tick = 3'h0;
        gfall = 3'h0;
        pin = 0;
        asyncMode = 1'b0;
        en = 1'b0;
        gated = 1'b0;
        ev = 1'b0;
        cnt32 = 32'h0000_0000;
        s_next = s_reg;
        // two-stage pin synchronisers, edge history reads stage two only
        s_next.sync1 = extClkPin;
        s_next.sync2 = s_reg.sync1;
        s_next.prev = s_reg.sync2;
        s_next.irq = 3'h0;
        s_next.dma = 2'h0;
        s_next.adcTrig = 1'b0;
        s_next.rdata = 16'h0000;
        pair32 = s_reg.ch[timer_pkg::CH_EV].ctl[timer_pkg::BIT_T32];
        for (int c = 0; c < 3; c++) begin
            // odd member follows even controls and pin when chained
            if (c == timer_pkg::CH_OD && pair32) begin
                cfg = s_reg.ch[timer_pkg::CH_EV].ctl;
                pin = timer_pkg::CH_EV;
            end else begin
                cfg = s_reg.ch[c].ctl;
                pin = c;
            end
            asyncMode = (c == timer_pkg::CH_SA) && cfg[timer_pkg::BIT_SRC]
                && !cfg[timer_pkg::BIT_SYNC];
            en = cfg[timer_pkg::BIT_RUN]
                && !(idleMode && cfg[timer_pkg::BIT_IDLE])
                && (!sleepMode || asyncMode);
            gated = cfg[timer_pkg::BIT_GATE] && !cfg[timer_pkg::BIT_SRC];
            if (cfg[timer_pkg::BIT_SRC]) begin
                ev = s_reg.sync2[pin] && !s_reg.prev[pin];
            end else if (gated) begin
                ev = s_reg.sync2[pin];
            end else begin
                ev = 1'b1;
            end
            if (!cfg[timer_pkg::BIT_RUN]) begin
                s_next.ch[c].pre = 8'h00;
            end else if (en && ev) begin
                if (s_reg.ch[c].pre >= psLimit(cfg[timer_pkg::BIT_PS_HI:timer_pkg::BIT_PS_LO])) begin
                    s_next.ch[c].pre = 8'h00;
                    tick[c] = 1'b1;
                end else begin
                    s_next.ch[c].pre = s_reg.ch[c].pre + 8'h01;
                end
            end
            gfall[c] = en && gated && !s_reg.sync2[pin] && s_reg.prev[pin];
            // independent 16-bit counting
            if (tick[c] && !(c != timer_pkg::CH_SA && pair32)) begin
                if (s_reg.ch[c].cnt == s_reg.ch[c].per) begin
                    s_next.ch[c].cnt = 16'h0000;
                    s_next.irq[c] = 1'b1;
                end else begin
                    s_next.ch[c].cnt = s_reg.ch[c].cnt + 16'h0001;
                end
            end
            if (gfall[c] && !(c == timer_pkg::CH_EV && pair32)) begin
                s_next.irq[c] = 1'b1;
            end
        end
        // chained 32-bit counting on the even member's tick
        cnt32 = {s_reg.ch[timer_pkg::CH_OD].cnt, s_reg.ch[timer_pkg::CH_EV].cnt};
        if (pair32 && tick[timer_pkg::CH_EV]) begin
            if (cnt32 == {s_reg.ch[timer_pkg::CH_OD].per, s_reg.ch[timer_pkg::CH_EV].per}) begin
                cnt32 = 32'h0000_0000;
                s_next.irq[timer_pkg::CH_OD] = 1'b1;
            end else begin
                cnt32 = cnt32 + 32'h0000_0001;
            end
            s_next.ch[timer_pkg::CH_OD].cnt = cnt32[31:16];
            s_next.ch[timer_pkg::CH_EV].cnt = cnt32[15:0];
        end
        s_next.adcTrig = s_next.irq[timer_pkg::CH_OD];
        s_next.dma = s_next.irq[timer_pkg::CH_OD:timer_pkg::CH_EV];
        // register writes win over counting
        if (busReq.wr) begin
            if (busReq.addr == timer_pkg::ADDR_SA_CTL) begin
                s_next.ch[timer_pkg::CH_SA].ctl = busReq.wdata & ctlMask(timer_pkg::CH_SA);
                s_next.ch[timer_pkg::CH_SA].pre = 8'h00;
            end else if (busReq.addr == timer_pkg::ADDR_SA_CNT) begin
                s_next.ch[timer_pkg::CH_SA].cnt = busReq.wdata;
            end else if (busReq.addr == timer_pkg::ADDR_SA_PER) begin
                s_next.ch[timer_pkg::CH_SA].per = busReq.wdata;
            end else if (busReq.addr == timer_pkg::ADDR_EV_CTL) begin
                s_next.ch[timer_pkg::CH_EV].ctl = busReq.wdata & ctlMask(timer_pkg::CH_EV);
                s_next.ch[timer_pkg::CH_EV].pre = 8'h00;
                s_next.ch[timer_pkg::CH_OD].pre = 8'h00;
            end else if (busReq.addr == timer_pkg::ADDR_EV_CNT) begin
                s_next.ch[timer_pkg::CH_EV].cnt = busReq.wdata;
            end else if (busReq.addr == timer_pkg::ADDR_EV_PER) begin
                s_next.ch[timer_pkg::CH_EV].per = busReq.wdata;
            end else if (busReq.addr == timer_pkg::ADDR_OD_CTL) begin
                s_next.ch[timer_pkg::CH_OD].ctl = busReq.wdata & ctlMask(timer_pkg::CH_OD);
                s_next.ch[timer_pkg::CH_OD].pre = 8'h00;
            end else if (busReq.addr == timer_pkg::ADDR_OD_CNT) begin
                s_next.ch[timer_pkg::CH_OD].cnt = busReq.wdata;
            end else if (busReq.addr == timer_pkg::ADDR_OD_PER) begin
                s_next.ch[timer_pkg::CH_OD].per = busReq.wdata;
            end
        end
        // read data one cycle after the strobe, unmapped reads zero
        if (busReq.rd) begin
            if (busReq.addr == timer_pkg::ADDR_SA_CTL) begin
                s_next.rdata = s_reg.ch[timer_pkg::CH_SA].ctl;
            end else if (busReq.addr == timer_pkg::ADDR_SA_CNT) begin
                s_next.rdata = s_reg.ch[timer_pkg::CH_SA].cnt;
            end else if (busReq.addr == timer_pkg::ADDR_SA_PER) begin
                s_next.rdata = s_reg.ch[timer_pkg::CH_SA].per;
            end else if (busReq.addr == timer_pkg::ADDR_EV_CTL) begin
                s_next.rdata = s_reg.ch[timer_pkg::CH_EV].ctl;
            end else if (busReq.addr == timer_pkg::ADDR_EV_CNT) begin
                s_next.rdata = s_reg.ch[timer_pkg::CH_EV].cnt;
            end else if (busReq.addr == timer_pkg::ADDR_EV_PER) begin
                s_next.rdata = s_reg.ch[timer_pkg::CH_EV].per;
            end else if (busReq.addr == timer_pkg::ADDR_OD_CTL) begin
                s_next.rdata = s_reg.ch[timer_pkg::CH_OD].ctl;
            end else if (busReq.addr == timer_pkg::ADDR_OD_CNT) begin
                s_next.rdata = s_reg.ch[timer_pkg::CH_OD].cnt;
            end else if (busReq.addr == timer_pkg::ADDR_OD_PER) begin
                s_next.rdata = s_reg.ch[timer_pkg::CH_OD].per;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < 3; c++) begin
                s_reg.ch[c].ctl <= timer_pkg::CTL_RESET;
                s_reg.ch[c].cnt <= timer_pkg::CNT_RESET;
                s_reg.ch[c].per <= timer_pkg::PER_RESET;
                s_reg.ch[c].pre <= 8'h00;
            end
            s_reg.sync1 <= 3'h0;
            s_reg.sync2 <= 3'h0;
            s_reg.prev <= 3'h0;
            s_reg.irq <= 3'h0;
            s_reg.adcTrig <= 1'b0;
            s_reg.dma <= 2'h0;
            s_reg.rdata <= 16'h0000;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;
    assign irqPulse = s_reg.irq;
    assign adcTrig = s_reg.adcTrig;
    assign dmaReq = s_reg.dma;
    assign timeBaseEven = s_reg.ch[timer_pkg::CH_EV].cnt;
    assign timeBaseOdd = s_reg.ch[timer_pkg::CH_OD].cnt;

endmodule

// ---- tb/timer16_pair32_checker.sv ----
/* checker for timer16_pair32: watches top ports only.
   assumes one clk domain; bound to the top at the foot. */
`timescale 1ns/1ns
module timer16_pair32_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire timer_pkg::bus_req_t busReq,
    input wire logic [15:0] rdata,
    input wire logic idleMode,
    input wire logic sleepMode,
    input wire logic [2:0] irqPulse,
    input wire logic adcTrig,
    input wire logic [1:0] dmaReq,
    input wire logic [15:0] timeBaseEven
);
    logic [15:0] evCtl_reg;
    logic [15:0] evPer_reg;
    logic ticking;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // shadow of even control and period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evCtl_reg <= 16'h0000;
            evPer_reg <= 16'hFFFF;
        end else if (busReq.wr && busReq.addr == timer_pkg::ADDR_EV_CTL) begin
            evCtl_reg <= busReq.wdata;
        end else if (busReq.wr && busReq.addr == timer_pkg::ADDR_EV_PER) begin
            evPer_reg <= busReq.wdata;
        end
    end
    assign ticking = evCtl_reg == 16'h8000 && !sleepMode && !busReq.wr;
    sequence stopWrite;
        busReq.wr && busReq.addr == timer_pkg::ADDR_EV_CTL && !busReq.wdata[15] ##1 !busReq.wr [*3];
    endsequence
    sequence twoTicks;
        ticking [*2];
    endsequence
    run_stops_a: assert property (stopWrite |=> $stable(timeBaseEven))
        else $error("even count moved after stop");
    idle_halt_a: assert property ((evCtl_reg == 16'hA000 && idleMode && !busReq.wr) [*2]
        |=> $stable(timeBaseEven)) else $error("even count moved in idle");
    sleep_halt_a: assert property ((evCtl_reg == 16'h8000 && sleepMode && !busReq.wr) [*2]
        |=> $stable(timeBaseEven)) else $error("even count moved in sleep");
    count_step_a: assert property (twoTicks |=> timeBaseEven ==
        ($past(timeBaseEven) == evPer_reg ? 16'h0000 : $past(timeBaseEven) + 16'h0001)) else $error("bad step");
    match_irq_a: assert property (twoTicks ##0 timeBaseEven == evPer_reg |-> ##[1:3] irqPulse[1])
        else $error("no irq on match");
    rdata_idle_a: assert property (!busReq.rd |=> rdata == 16'h0000)
        else $error("read data without read");
    adc_follow_a: assert property (adcTrig == irqPulse[2])
        else $error("trigger differs from odd irq");
    dma_follow_a: assert property (dmaReq == irqPulse[2:1])
        else $error("dma differs from pair irq");
endmodule
bind timer16_pair32 timer16_pair32_checker timer16_pair32_checker_inst (.clk, .rst_n, .busReq, .rdata,
    .idleMode, .sleepMode, .irqPulse, .adcTrig, .dmaReq, .timeBaseEven);

// ---- tb/timer16_pair32_bench.sv ----
/* self-checking bench for timer16_pair32.
   assumes 20 MHz clk and the plain register port. */
`timescale 1ns/1ns
module timer16_pair32_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    timer_pkg::bus_req_t busReq = '0;
    logic [15:0] rdata;
    logic [2:0] extClkPin = 3'h0;
    logic idleMode = 1'b0;
    logic sleepMode = 1'b0;
    logic [2:0] irqPulse;
    logic [15:0] timeBaseEven;
    logic [15:0] timeBaseOdd;
    logic [15:0] val;
    logic [15:0] msk [3] = '{16'hA076, 16'hA07A, 16'hA072};
    int divs [4] = '{1, 8, 64, 256};
    int nFail = 0;
    int samplesChecked = 0;
    int n;
    always #25 clk = ~clk;
    timer16_pair32 timer16_pair32_inst (.clk, .rst_n, .busReq, .rdata, .extClkPin, .idleMode, .sleepMode,
        .irqPulse, .adcTrig(), .dmaReq(), .timeBaseEven, .timeBaseOdd);
    task automatic summarize();
        if (nFail == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nFail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk);
        busReq <= '{ad, d, 1'b1, 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [15:0] v);
        @(posedge clk);
        busReq <= '{ad, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    task automatic delta(input logic [3:0] ad, input logic [15:0] exp);
        logic [15:0] x;
        logic [15:0] y;
        rd(ad, x);
        rd(ad, y);
        check(16'(y - x), exp);
    endtask
    task automatic waitIrq(input int i, input int lim, output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (irqPulse[i] !== 1'b1 && c < lim);
        if (irqPulse[i] !== 1'b1) begin
            nFail++;
            summarize();
        end
    endtask
    task automatic pulses(input int pin, input int k);
        repeat (k) begin
            @(posedge clk);
            extClkPin[pin] <= 1'b1;
            repeat (4) @(posedge clk);
            extClkPin[pin] <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wr(4'h9, 16'hFFFF);
        for (int i = 0; i < 10; i++) begin
            rd(4'(i), val);
            check(val, (i % 3 == 2) ? 16'hFFFF : 16'h0000);
        end
        for (int i = 0; i < 3; i++) begin
            wr(4'(3 * i), 16'hFFFF);
            rd(4'(3 * i), val);
            check(val, msk[i]);
            wr(4'(3 * i), 16'h0000);
        end
        wr(4'h2, 16'h0002);
        for (int p = 0; p < 4; p++) begin
            wr(4'h0, 16'(16'h8000 | (p << 4)));
            waitIrq(0, 800, n);
            waitIrq(0, 800, n);
            check(n, 3 * divs[p]);
        end
        wr(4'h0, 16'h0000);
        delta(4'h1, 16'h0000);
        wr(4'h3, 16'hA000);
        idleMode <= 1'b1;
        delta(4'h4, 16'h0000);
        wr(4'h3, 16'h8000);
        delta(4'h4, 16'h0002);
        @(posedge clk);
        sleepMode <= 1'b1;
        delta(4'h4, 16'h0000);
        wr(4'h2, 16'hFFFF);
        wr(4'h0, 16'h8002);
        wr(4'h1, 16'h0000);
        pulses(0, 3);
        rd(4'h1, val);
        check(val, 16'h0003);
        wr(4'h0, 16'h8006);
        wr(4'h1, 16'h0000);
        pulses(0, 3);
        rd(4'h1, val);
        check(val, 16'h0000);
        @(posedge clk);
        sleepMode <= 1'b0;
        idleMode <= 1'b0;
        wr(4'h5, 16'h0004);
        wr(4'h4, 16'h0000);
        waitIrq(1, 20, n);
        waitIrq(1, 20, n);
        check(n, 5);
        wr(4'h0, 16'h8040);
        delta(4'h1, 16'h0000);
        @(posedge clk);
        extClkPin[0] <= 1'b1;
        repeat (4) @(posedge clk);
        delta(4'h1, 16'h0002);
        @(posedge clk);
        extClkPin[0] <= 1'b0;
        waitIrq(0, 8, n);
        check(irqPulse[0], 1'b1);
        wr(4'h3, 16'h8002);
        wr(4'h4, 16'h0000);
        pulses(1, 2);
        rd(4'h4, val);
        check(val, 16'h0002);
        wr(4'h6, 16'h8002);
        wr(4'h7, 16'h0000);
        pulses(2, 2);
        rd(4'h7, val);
        check(val, 16'h0002);
        wr(4'h3, 16'h0000);
        repeat (4) @(posedge clk);
        wr(4'h6, 16'h0030);
        wr(4'h8, 16'h0001);
        wr(4'h5, 16'h0003);
        wr(4'h7, 16'h0000);
        wr(4'h4, 16'hFFFE);
        wr(4'h3, 16'h8008);
        repeat (3) @(negedge clk);
        check({timeBaseOdd, timeBaseEven}, 32'h0001_0000);
        waitIrq(2, 10, n);
        waitIrq(2, 70000, n);
        check(n, 32'h10004);
        summarize();
    end
endmodule
